// *** dv/positioner_flag_bank_properties.sv ***
`timescale 1ns/1ps
module flag_bank_chk (
    input wire        clk,
    input wire        resetn,
    input wire        host_wr,
    input wire        host_ack_q,
    input wire        host_reject_q,
    input wire        link_lost,
    input wire        restore_vars_q,
    input wire        fail_hold_last_q,
    input wire        fail_last_cmd_q,
    input wire        fail_close_q,
    input wire        fail_open_q,
    input wire        led_red_q,
    input wire        led_yellow_q,
    input wire        led_green_q,
    input wire [3:0]  host_index,
    input wire [15:0] host_wdata,
    input wire [7:0]  temperature_unit_q,
    input wire [7:0]  travel_unit_q
);
    // ------------------------------
    // Properties
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_hold_last: assert property (fail_hold_last_q |-> $past(link_lost)) else $error("hold");
    chk_one_action: assert property (
        $onehot0({fail_hold_last_q, fail_last_cmd_q, fail_close_q, fail_open_q})) else $error("action");
    chk_multi_action: assert property (
        host_wr && host_index == 4'h0 && !$onehot0(host_wdata[2:0]) |=> host_reject_q) else $error("multi");
    chk_restore_vars: assert property (
        host_wr && host_index == 4'h2 && host_wdata[7:0] == 8'h01 |=> restore_vars_q) else $error("restore");
    chk_temp_code: assert property (temperature_unit_q inside {8'h20, 8'h21}) else $error("temp");
    chk_travel_code: assert property (travel_unit_q inside {8'h2f, 8'h31}) else $error("travel");
    chk_led_single: assert property ($onehot0({led_red_q, led_yellow_q, led_green_q})) else $error("led");
    chk_ro_reject: assert property (
        host_wr && host_index inside {4'h1, 4'h4, 4'h6, 4'h9} |=> host_ack_q && host_reject_q) else $error("ro");
    cover property (fail_hold_last_q);
    cover property (restore_vars_q);
    cover property (host_reject_q);
endmodule // flag_bank_chk
bind positioner_flag_bank flag_bank_chk u_chk (.*);

// *** dv/positioner_flag_bank_test.sv ***
`timescale 1ns/1ps
module positioner_flag_bank_test;
    logic clk = 0, resetn = 0, host_wr = 0, host_rd = 0, link_lost = 0, advanced_model = 0, piezo_out_of_range = 0;
    logic sig_in_valid = 0, sig_in_last = 0, sig_done = 0, host_ack_q, host_reject_q, fail_hold_last_q, fail_last_cmd_q;
    logic fail_close_q, fail_open_q, restore_vars_q, restore_cal_q, recal_button_off_q, large_actuator_cal_q;
    logic model_detect_off_q, pressure_ctrl_en_q, auto_gain_en_q, elec_in_deviation_q, jog_cal_en_q, led_red_q;
    logic led_yellow_q, led_green_q, scan_list_en_q, sig_in_ready_q, sig_out_valid_q, sig_out_last_q;
    logic [3:0]  host_index = 0;
    logic [6:0]  sig_progress = 0;
    logic [15:0] host_wdata = 0, loop_dac = 16'h0abc, dac_out_q;
    logic [7:0]  elec_raw = 0, press_raw = 0, travel_raw = 0, cal_faults = 0, sig_in_data = 0, host_rdata_q;
    logic [7:0]  sig_out_data_q, pressure_unit_q, temperature_unit_q, travel_unit_q;
    int num_errors = 0, n_compared = 0;
    logic [4:0]  seen;
    // Index, data, refused, read back
    logic [23:0] tbl [26] = '{24'h507007, 24'h50a00a, 24'h50c00c, 24'h506006, 24'h508106, 24'h721021, 24'h722121,
        24'h720020, 24'ha31031, 24'ha30131, 24'ha2f02f, 24'h003100, 24'h004004, 24'h009104, 24'h001001, 24'h806100,
        24'h80a100, 24'h8f4084, 24'h801001, 24'h1ff100, 24'h4ff100, 24'h6ff100, 24'h9ff100, 24'hc00100, 24'h3ff0df,
        24'h203100};
    positioner_flag_bank #(.BLINK_HALF(4)) dut (.*);
    task chk(input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("Error %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] i, input logic [15:0] d, input logic r);
        @(negedge clk);
        {host_wr, host_index, host_wdata} = {1'b1, i, d};
        @(negedge clk);
        host_wr = 0;
        chk({host_ack_q, host_reject_q}, {1'b1, r});
    endtask
    task rd(input logic [3:0] i, input logic [7:0] e);
        @(negedge clk);
        {host_rd, host_index} = {1'b1, i};
        @(negedge clk);
        host_rd = 0;
        chk(host_rdata_q, e);
    endtask
    task print_verdict;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1;
        foreach (tbl[k]) begin
            wr(tbl[k][23:20], tbl[k][19:12], tbl[k][8]);
            rd(tbl[k][23:20], tbl[k][7:0]);
        end
        chk({recal_button_off_q, large_actuator_cal_q, model_detect_off_q, pressure_ctrl_en_q, auto_gain_en_q,
            elec_in_deviation_q, jog_cal_en_q}, 16'h7f);
        wr(4'hb, 16'h1234, 0);
        repeat (2) @(negedge clk);
        chk(dac_out_q, 16'h1234);
        link_lost = 1;
        repeat (2) @(negedge clk);
        chk({fail_last_cmd_q, fail_close_q, fail_open_q, fail_hold_last_q}, 16'h8);
        wr(0, 16'h0002, 0);
        repeat (2) @(negedge clk);
        chk({fail_last_cmd_q, fail_close_q, fail_open_q, fail_hold_last_q}, 16'h4);
        wr(0, 16'h0004, 0);
        repeat (2) @(negedge clk);
        chk({fail_last_cmd_q, fail_close_q, fail_open_q, fail_hold_last_q}, 16'h2);
        wr(0, 0, 0);
        repeat (2) @(negedge clk);
        chk(fail_hold_last_q, 1);
        {elec_raw, press_raw, travel_raw, cal_faults} = 32'hffff_8101;
        repeat (3) @(negedge clk);
        rd(1, 8'h9f);
        rd(4, 8'h00);
        rd(6, 8'h17);
        {piezo_out_of_range, advanced_model} = 2'b11;
        repeat (3) @(negedge clk);
        rd(1, 8'hbf);
        rd(4, 8'h0d);
        rd(9, 8'h81);
        rd(6, 8'h1f);
        {elec_raw, press_raw, travel_raw, cal_faults, piezo_out_of_range, link_lost} = 0;
        repeat (3) @(negedge clk);
        rd(6, 8'h00);
        wr(5, 16'h000c, 0);
        wr(2, 1, 0);
        chk({restore_cal_q, restore_vars_q}, 16'h1);
        chk({pressure_unit_q, travel_unit_q}, 16'h062f);
        rd(3, 8'h00);
        chk(dac_out_q, 16'h0abc);
        wr(8, 16'h0088, 0);
        seen = 0;
        repeat (10) begin
            @(negedge clk);
            seen |= {led_red_q, led_yellow_q, led_green_q, !led_green_q, scan_list_en_q};
        end
        chk(seen, 16'h07);
        wr(2, 2, 0);
        chk({restore_cal_q, restore_vars_q}, 16'h2);
        rd(8, 8'h88);
        {sig_in_valid, sig_in_last, sig_done, sig_in_data, sig_progress} = {3'b111, 8'h5a, 7'h15};
        @(negedge clk);
        sig_in_valid = 0;
        chk({sig_in_ready_q, sig_out_valid_q, sig_out_data_q}, 16'h15a);
        @(negedge clk);
        chk({sig_in_ready_q, sig_out_valid_q, sig_out_last_q, sig_out_data_q}, 16'h795);
        print_verdict;
    end
endmodule // positioner_flag_bank_test

// *** logic/fault_byte_latch.v ***
`timescale 1ns/1ps

// ----------------------------------------
// Registered fault byte with group summary
// ----------------------------------------
module fault_byte_latch #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire         enable,
    input  wire [W-1:0] raw,
    input  wire [W-1:0] mask,
    output reg  [W-1:0] flags_q,
    output reg          any_q
);

    wire [W-1:0] flags_d;

    // Unused bits and a disabled group always read as no error
    assign flags_d = enable ? (raw & mask) : {W{1'b0}};

    always @(posedge clk) begin
        if (!resetn) begin
            flags_q <= {W{1'b0}};
            any_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            any_q   <= |flags_d;
        end
    end

endmodule // fault_byte_latch

// *** logic/positioner_flag_bank.v ***
// Behaviour
// - Fail-action byte zero holds valve at last known position on link loss.
// - Bit0 last commanded, bit1 close at 0%, bit2 open at 100%.
// - Fail-action writes with more than one bit set are rejected.
// - Electronics byte flags reference, DAC, temperature, Hall and checksum errors.
// - Electronics bit 5 is set by piezo drive voltage out of range.
// - Restore command 1 reloads variables, 2 reloads calibration constants.
// - Feature bits 0..2: recal button off, large actuator, no model detect.
// - Feature bits 3,4,6,7 enable pressure, gain, deviation, jog; bit5 unused.
// - Advanced model only: pressure bits 0, 2, 3 for supply and ports.
// - Pressure unit codes 6, 7, 10, 12 only.
// - Summary bits 0..3 follow calibration, travel, electronics, pressure groups.
// - Summary bit 4 is communications error; bits 5..7 read zero.
// - Temperature unit codes 32 and 33 only.
// - Board test bit 0 drives converter from host value.
// - Board test bits 1..3 blink red, yellow, green; only one at once.
// - Board test bit 7 enables scan list; bits 4..6 reserved.
// - Travel bit 0 setpoint cutoff, bits 1, 2 lower/upper soft stop.
// - Travel bits 3..7: position alerts, cycle, accumulator, deviation.
// - Travel unit codes 47 inches and 49 millimetres only.
// - Progress byte appended after every signature data frame.
// - In every fault byte one means error active, zero no error.
`timescale 1ns/1ps
`include "positioner_flag_bank_consts.vh"

module positioner_flag_bank #(
    parameter BLINK_HALF = `BLINK_HALF_CYCLES,
    parameter DAC_W      = 16
) (
    input  wire             clk,
    input  wire             resetn,
    // Host variable access
    input  wire             host_wr,
    input  wire             host_rd,
    input  wire [3:0]       host_index,
    input  wire [15:0]      host_wdata,
    output reg  [7:0]       host_rdata_q,
    output reg              host_ack_q,
    output reg              host_reject_q,
    // Link state and fail action
    input  wire             link_lost,
    output reg              fail_hold_last_q,
    output reg              fail_last_cmd_q,
    output reg              fail_close_q,
    output reg              fail_open_q,
    // Fault sources
    input  wire             advanced_model,
    input  wire [7:0]       elec_raw,
    input  wire             piezo_out_of_range,
    input  wire [7:0]       press_raw,
    input  wire [7:0]       travel_raw,
    input  wire [7:0]       cal_faults,
    // Restore commands
    output reg              restore_vars_q,
    output reg              restore_cal_q,
    // Feature controls
    output reg              recal_button_off_q,
    output reg              large_actuator_cal_q,
    output reg              model_detect_off_q,
    output reg              pressure_ctrl_en_q,
    output reg              auto_gain_en_q,
    output reg              elec_in_deviation_q,
    output reg              jog_cal_en_q,
    // Converter and board test
    input  wire [DAC_W-1:0] loop_dac,
    output reg  [DAC_W-1:0] dac_out_q,
    output reg              led_red_q,
    output reg              led_yellow_q,
    output reg              led_green_q,
    output reg              scan_list_en_q,
    // Unit codes
    output reg  [7:0]       pressure_unit_q,
    output reg  [7:0]       temperature_unit_q,
    output reg  [7:0]       travel_unit_q,
    // Signature frames
    input  wire             sig_in_valid,
    input  wire [7:0]       sig_in_data,
    input  wire             sig_in_last,
    input  wire [6:0]       sig_progress,
    input  wire             sig_done,
    output reg              sig_in_ready_q,
    output reg              sig_out_valid_q,
    output reg  [7:0]       sig_out_data_q,
    output reg              sig_out_last_q
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function at_most_one;
        input [7:0] v;
        begin
            at_most_one = ((v & (v - 8'h01)) == 8'h00);
        end
    endfunction

    function unit_ok;
        input [7:0] v;
        input [7:0] a;
        input [7:0] b;
        input [7:0] c;
        input [7:0] d;
        begin
            unit_ok = (v == a) || (v == b) || (v == c) || (v == d);
        end
    endfunction

    // ----------------------------------------
    // Host writable state
    // ----------------------------------------
    reg  [7:0]       link_loss_action_q;
    reg  [7:0]       feature_enables_q;
    reg  [7:0]       board_test_select_q;
    reg  [DAC_W-1:0] dac_host_value_q;

    wire [7:0] wbyte;
    wire       wr_link;
    wire       wr_feat;
    wire       wr_punit;
    wire       wr_tunit;
    wire       wr_test;
    wire       wr_lunit;
    wire       wr_dac;
    wire       wr_restore;
    wire       link_ok;
    wire       punit_ok;
    wire       tunit_ok;
    wire       lunit_ok;
    wire       test_ok;
    wire       restore_ok;
    wire       restore_vars;

    assign wbyte      = host_wdata[7:0];
    assign wr_link    = host_wr && (host_index == `IDX_LINK_LOSS_ACTION);
    assign wr_feat    = host_wr && (host_index == `IDX_FEATURE_ENABLES);
    assign wr_punit   = host_wr && (host_index == `IDX_PRESSURE_UNIT_SEL);
    assign wr_tunit   = host_wr && (host_index == `IDX_TEMPERATURE_UNIT_SEL);
    assign wr_test    = host_wr && (host_index == `IDX_BOARD_TEST_SELECT);
    assign wr_lunit   = host_wr && (host_index == `IDX_TRAVEL_UNIT_SEL);
    assign wr_dac     = host_wr && (host_index == `IDX_DAC_HOST_VALUE);
    assign wr_restore = host_wr && (host_index == `IDX_FACTORY_RESTORE_CMD);

    // Bits 7..3 must be clear and any two of the three action bits set is illegal
    assign link_ok    = at_most_one(wbyte & 8'h07) && (wbyte[7:3] == 5'h00);
    assign punit_ok   = unit_ok(wbyte, `PUNIT_PSI, `PUNIT_BAR,
                                `PUNIT_KG_CM2, `PUNIT_KPA);
    assign tunit_ok   = unit_ok(wbyte, `TUNIT_CELSIUS, `TUNIT_FAHRENHEIT,
                                `TUNIT_CELSIUS, `TUNIT_FAHRENHEIT);
    assign lunit_ok   = unit_ok(wbyte, `LUNIT_INCHES, `LUNIT_MILLIMETRES,
                                `LUNIT_INCHES, `LUNIT_MILLIMETRES);
    assign test_ok    = at_most_one(wbyte & 8'h0e);
    assign restore_ok = (wbyte == `RESTORE_VARIABLES) ||
                        (wbyte == `RESTORE_CAL_CONSTANTS);
    assign restore_vars = wr_restore && (wbyte == `RESTORE_VARIABLES);

    // Restoring variables takes priority over a write in the same cycle,
    // which cannot happen on this single port but keeps the order explicit
    always @(posedge clk) begin
        if (!resetn || restore_vars) begin
            link_loss_action_q  <= `RST_LINK_LOSS_ACTION;
            feature_enables_q   <= `RST_FEATURE_ENABLES;
            board_test_select_q <= `RST_BOARD_TEST_SELECT;
            dac_host_value_q    <= `RST_DAC_HOST_VALUE;
            pressure_unit_q     <= `RST_PRESSURE_UNIT_SEL;
            temperature_unit_q  <= `RST_TEMPERATURE_UNIT_SEL;
            travel_unit_q       <= `RST_TRAVEL_UNIT_SEL;
        end else begin
            if (wr_link && link_ok) begin
                link_loss_action_q <= wbyte;
            end
            if (wr_feat) begin
                feature_enables_q <= wbyte & `FEAT_USED_MASK;
            end
            if (wr_test && test_ok) begin
                board_test_select_q <= wbyte & `TEST_USED_MASK;
            end
            if (wr_dac) begin
                dac_host_value_q <= host_wdata[DAC_W-1:0];
            end
            if (wr_punit && punit_ok) begin
                pressure_unit_q <= wbyte;
            end
            if (wr_tunit && tunit_ok) begin
                temperature_unit_q <= wbyte;
            end
            if (wr_lunit && lunit_ok) begin
                travel_unit_q <= wbyte;
            end
        end
    end

    // ----------------------------------------
    // Restore command strobes
    // ----------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            restore_vars_q <= 1'b0;
            restore_cal_q  <= 1'b0;
        end else begin
            restore_vars_q <= restore_vars;
            restore_cal_q  <= wr_restore && (wbyte == `RESTORE_CAL_CONSTANTS);
        end
    end

    // ----------------------------------------
    // Fault bytes
    // ----------------------------------------
    wire [7:0] elec_flags;
    wire [7:0] press_flags;
    wire [7:0] travel_flags;
    wire       elec_any;
    wire       press_any;
    wire       travel_any;
    wire       cal_any;
    wire [7:0] elec_src;

    // Bit 5 is named for modulator current but carries the piezo check
    assign elec_src = {elec_raw[7:6], piezo_out_of_range, elec_raw[4:0]};

    fault_byte_latch #(.W(8)) u_elec (
        .clk     (clk),
        .resetn  (resetn),
        .enable  (1'b1),
        .raw     (elec_src),
        .mask    (`ELEC_USED_MASK),
        .flags_q (elec_flags),
        .any_q   (elec_any)
    );

    fault_byte_latch #(.W(8)) u_press (
        .clk     (clk),
        .resetn  (resetn),
        .enable  (advanced_model),
        .raw     (press_raw),
        .mask    (`PRESS_USED_MASK),
        .flags_q (press_flags),
        .any_q   (press_any)
    );

    fault_byte_latch #(.W(8)) u_travel (
        .clk     (clk),
        .resetn  (resetn),
        .enable  (1'b1),
        .raw     (travel_raw),
        .mask    (8'hff),
        .flags_q (travel_flags),
        .any_q   (travel_any)
    );

    fault_byte_latch #(.W(8)) u_cal (
        .clk     (clk),
        .resetn  (resetn),
        .enable  (1'b1),
        .raw     (cal_faults),
        .mask    (8'hff),
        .flags_q (),
        .any_q   (cal_any)
    );

    // ----------------------------------------
    // Summary alarms
    // ----------------------------------------
    reg [7:0] summary_q;

    // Level copy of group state, so a bit drops once its group is clean
    always @(posedge clk) begin
        if (!resetn) begin
            summary_q <= 8'h00;
        end else begin
            summary_q <= {3'b000, link_lost, press_any, elec_any,
                          travel_any, cal_any};
        end
    end

    // ----------------------------------------
    // Host read and answer
    // ----------------------------------------
    reg [7:0] rd_mux;
    reg       idx_known;

    always @* begin
        idx_known = 1'b1;
        case (host_index)
            `IDX_LINK_LOSS_ACTION:     rd_mux = link_loss_action_q;
            `IDX_ELECTRONICS_FAULTS:   rd_mux = elec_flags;
            `IDX_FACTORY_RESTORE_CMD:  rd_mux = 8'h00;
            `IDX_FEATURE_ENABLES:      rd_mux = feature_enables_q;
            `IDX_PRESSURE_FAULTS:      rd_mux = press_flags;
            `IDX_PRESSURE_UNIT_SEL:    rd_mux = pressure_unit_q;
            `IDX_SUMMARY_ALARMS:       rd_mux = summary_q;
            `IDX_TEMPERATURE_UNIT_SEL: rd_mux = temperature_unit_q;
            `IDX_BOARD_TEST_SELECT:    rd_mux = board_test_select_q;
            `IDX_TRAVEL_ALERTS:        rd_mux = travel_flags;
            `IDX_TRAVEL_UNIT_SEL:      rd_mux = travel_unit_q;
            `IDX_DAC_HOST_VALUE:       rd_mux = dac_host_value_q[7:0];
            default: begin
                rd_mux    = 8'h00;
                idx_known = 1'b0;
            end
        endcase
    end

    // Writes to read-only bytes, bad codes and unknown indices are refused
    wire wr_refused;
    assign wr_refused = (wr_link && !link_ok) || (wr_punit && !punit_ok) ||
                        (wr_tunit && !tunit_ok) || (wr_test && !test_ok) ||
                        (wr_lunit && !lunit_ok) || (wr_restore && !restore_ok) ||
                        (host_wr && !idx_known) ||
                        (host_wr && ((host_index == `IDX_ELECTRONICS_FAULTS) ||
                                     (host_index == `IDX_PRESSURE_FAULTS) ||
                                     (host_index == `IDX_SUMMARY_ALARMS) ||
                                     (host_index == `IDX_TRAVEL_ALERTS)));

    always @(posedge clk) begin
        if (!resetn) begin
            host_rdata_q  <= 8'h00;
            host_ack_q    <= 1'b0;
            host_reject_q <= 1'b0;
        end else begin
            host_ack_q    <= host_wr || host_rd;
            host_reject_q <= wr_refused || (host_rd && !host_wr && !idx_known);
            if (host_rd && !host_wr) begin
                host_rdata_q <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Fail action outputs
    // ----------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            fail_hold_last_q <= 1'b0;
            fail_last_cmd_q  <= 1'b0;
            fail_close_q     <= 1'b0;
            fail_open_q      <= 1'b0;
        end else begin
            fail_hold_last_q <= link_lost && (link_loss_action_q == 8'h00);
            fail_last_cmd_q  <= link_lost && link_loss_action_q[`FAIL_LAST_CMD_BIT];
            fail_close_q     <= link_lost && link_loss_action_q[`FAIL_CLOSE_BIT];
            fail_open_q      <= link_lost && link_loss_action_q[`FAIL_OPEN_BIT];
        end
    end

    // ----------------------------------------
    // Feature controls
    // ----------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            recal_button_off_q   <= 1'b0;
            large_actuator_cal_q <= 1'b0;
            model_detect_off_q   <= 1'b0;
            pressure_ctrl_en_q   <= 1'b0;
            auto_gain_en_q       <= 1'b0;
            elec_in_deviation_q  <= 1'b0;
            jog_cal_en_q         <= 1'b0;
        end else begin
            recal_button_off_q   <= feature_enables_q[0];
            large_actuator_cal_q <= feature_enables_q[1];
            model_detect_off_q   <= feature_enables_q[2];
            pressure_ctrl_en_q   <= feature_enables_q[3];
            auto_gain_en_q       <= feature_enables_q[4];
            elec_in_deviation_q  <= feature_enables_q[6];
            jog_cal_en_q         <= feature_enables_q[7];
        end
    end

    // ----------------------------------------
    // Board test: converter source and indicators
    // ----------------------------------------
    reg [31:0] blink_cnt_q;
    reg        blink_phase_q;

    // A free blink phase keeps the three indicators in step with each other
    always @(posedge clk) begin
        if (!resetn) begin
            blink_cnt_q   <= 32'h0000_0000;
            blink_phase_q <= 1'b0;
        end else if (blink_cnt_q >= BLINK_HALF - 1) begin
            blink_cnt_q   <= 32'h0000_0000;
            blink_phase_q <= ~blink_phase_q;
        end else begin
            blink_cnt_q   <= blink_cnt_q + 32'h0000_0001;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            dac_out_q      <= {DAC_W{1'b0}};
            led_red_q      <= 1'b0;
            led_yellow_q   <= 1'b0;
            led_green_q    <= 1'b0;
            scan_list_en_q <= 1'b0;
        end else begin
            dac_out_q      <= board_test_select_q[`TEST_DAC_BIT] ?
                              dac_host_value_q : loop_dac;
            led_red_q      <= board_test_select_q[`TEST_RED_BIT] && blink_phase_q;
            led_yellow_q   <= board_test_select_q[`TEST_YELLOW_BIT] && blink_phase_q;
            led_green_q    <= board_test_select_q[`TEST_GREEN_BIT] && blink_phase_q;
            scan_list_en_q <= board_test_select_q[`TEST_SCAN_BIT];
        end
    end

    // ----------------------------------------
    // Signature frame appender
    // ----------------------------------------
    localparam [1:0] SIG_PASS   = 2'b01;
    localparam [1:0] SIG_APPEND = 2'b10;

    reg  [1:0] sig_state_q;
    wire       sig_take;

    assign sig_take = sig_in_valid && sig_in_ready_q;

    always @(posedge clk) begin
        if (!resetn) begin
            sig_state_q     <= SIG_PASS;
            sig_in_ready_q  <= 1'b0;
            sig_out_valid_q <= 1'b0;
            sig_out_data_q  <= 8'h00;
            sig_out_last_q  <= 1'b0;
        end else begin
            case (sig_state_q)
                SIG_PASS: begin
                    sig_out_valid_q <= sig_take;
                    sig_out_data_q  <= sig_take ? sig_in_data : 8'h00;
                    sig_out_last_q  <= 1'b0;
                    sig_in_ready_q  <= !(sig_take && sig_in_last);
                    if (sig_take && sig_in_last) begin
                        sig_state_q <= SIG_APPEND;
                    end
                end
                SIG_APPEND: begin
                    // Input is stalled for this one cycle to make room
                    sig_out_valid_q <= 1'b1;
                    sig_out_data_q  <= {sig_done, sig_progress};
                    sig_out_last_q  <= 1'b1;
                    sig_in_ready_q  <= 1'b1;
                    sig_state_q     <= SIG_PASS;
                end
                default: begin
                    sig_state_q     <= SIG_PASS;
                    sig_in_ready_q  <= 1'b0;
                    sig_out_valid_q <= 1'b0;
                    sig_out_data_q  <= 8'h00;
                    sig_out_last_q  <= 1'b0;
                end
            endcase
        end
    end

endmodule // positioner_flag_bank

// *** logic/positioner_flag_bank_consts.vh ***
`ifndef POSITIONER_FLAG_BANK_CONSTS_VH
`define POSITIONER_FLAG_BANK_CONSTS_VH

// ----------------------------------------
// Variable indices on the host access port
// ----------------------------------------
`define IDX_LINK_LOSS_ACTION     4'h0
`define IDX_ELECTRONICS_FAULTS   4'h1
`define IDX_FACTORY_RESTORE_CMD  4'h2
`define IDX_FEATURE_ENABLES      4'h3
`define IDX_PRESSURE_FAULTS      4'h4
`define IDX_PRESSURE_UNIT_SEL    4'h5
`define IDX_SUMMARY_ALARMS       4'h6
`define IDX_TEMPERATURE_UNIT_SEL 4'h7
`define IDX_BOARD_TEST_SELECT    4'h8
`define IDX_TRAVEL_ALERTS        4'h9
`define IDX_TRAVEL_UNIT_SEL      4'ha
`define IDX_DAC_HOST_VALUE       4'hb

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FAIL_LAST_CMD_BIT        0
`define FAIL_CLOSE_BIT           1
`define FAIL_OPEN_BIT            2
`define ELEC_PIEZO_BIT           5
`define ELEC_USED_MASK           8'hbf
`define PRESS_USED_MASK          8'h0d
`define FEAT_USED_MASK           8'hdf
`define TEST_DAC_BIT             0
`define TEST_RED_BIT             1
`define TEST_YELLOW_BIT          2
`define TEST_GREEN_BIT           3
`define TEST_SCAN_BIT            7
`define TEST_USED_MASK           8'h8f
`define SIG_END_BIT              7

// ----------------------------------------
// Command and unit codes
// ----------------------------------------
`define RESTORE_VARIABLES        8'h01
`define RESTORE_CAL_CONSTANTS    8'h02
`define PUNIT_PSI                8'h06
`define PUNIT_BAR                8'h07
`define PUNIT_KG_CM2             8'h0a
`define PUNIT_KPA                8'h0c
`define TUNIT_CELSIUS            8'h20
`define TUNIT_FAHRENHEIT         8'h21
`define LUNIT_INCHES             8'h2f
`define LUNIT_MILLIMETRES        8'h31

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_LINK_LOSS_ACTION     8'h00
`define RST_FEATURE_ENABLES      8'h00
`define RST_PRESSURE_UNIT_SEL    `PUNIT_PSI
`define RST_TEMPERATURE_UNIT_SEL `TUNIT_CELSIUS
`define RST_BOARD_TEST_SELECT    8'h00
`define RST_TRAVEL_UNIT_SEL      `LUNIT_INCHES
`define RST_DAC_HOST_VALUE       16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ                  125
`define BLINK_HALF_MS            250
`define BLINK_HALF_CYCLES        (`BLINK_HALF_MS * 1000 * `CLK_MHZ)

`endif
